// *** rtl/pvc_params.svh ***
// Register offsets, field positions, reset values and timing counts for the calibration control.
`ifndef PVC_PARAMS_SVH
`define PVC_PARAMS_SVH

`define PVC_ADDR_TUNE 8'h59
`define PVC_ADDR_HOLD 8'h5C
`define PVC_ADDR_CTRL 8'h5D
`define PVC_ADDR_STAT 8'h5E
`define PVC_ADDR_RUN 8'h61

`define PVC_RST_TUNE 7'h00
`define PVC_RST_HOLD 1'b0
`define PVC_RST_SETTLE 3'h4
`define PVC_RST_CALEN 1'b0
`define PVC_RST_RUN 1'b1

`define PVC_TUNE_MSB 6
`define PVC_SETTLE_MSB 6
`define PVC_SETTLE_LSB 4
`define PVC_TUNE_MID 7'h40
`define PVC_TUNE_MAX 7'h7F

// Settle wait is (code + 1) * base, in reference clock cycles.
`define PVC_SETTLE_BASE_NS 320
`define PVC_CLK_NS 40
`define PVC_SETTLE_BASE_CYC ((`PVC_SETTLE_BASE_NS + `PVC_CLK_NS - 1) / `PVC_CLK_NS)

`endif

// *** rtl/pvc_pkg.sv ***
// Types shared by the calibration control design.
package pvc_pkg;
  typedef enum logic [1:0] {
    PVC_IDLE = 2'b00,
    PVC_STEP = 2'b01,
    PVC_SETTLE = 2'b10,
    PVC_DONE = 2'b11
  } pvc_state_t;
endpackage

// *** rtl/pvc_settle_timer.sv ***
// Settle-time down counter loaded from the settle-time code.
`timescale 1ns/1ps
`default_nettype none
`include "pvc_params.svh"
module pvc_settle_timer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [2:0] settle_code,
  output logic expired
);
  logic [7:0] count;
  logic [7:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      // Larger code, longer wait.
      next_count = 8'((settle_code + 4'h1) * `PVC_SETTLE_BASE_CYC); // RULE_05
    end else if (count != 8'h00) begin
      next_count = count - 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else begin
      count <= next_count;
    end
  end

  assign expired = (count == 8'h01);
endmodule
`default_nettype wire

// *** rtl/pvc_cal_control.sv ***
// Register file and oscillator tune engine for PLL and converter calibration control.
`timescale 1ns/1ps
`default_nettype none
`include "pvc_params.svh"

// Summary of operation
// [RULE_01] A 7-bit tune word sits in bits 6:0, written by the engine and by the host.
// [RULE_02] The host may read the tune word after calibration and restore it later.
// [RULE_03] The host should not touch the tune word while calibration is running.
// [RULE_04] The host sets the hold bit before PLL programming and clears it afterwards.
// [RULE_05] The 3-bit settle code, reset 0x4, sets the wait after each tune step, larger is longer.
// [RULE_06] With calibration enabled, calibration starts when the hold bit is written to 0.
// [RULE_07] The engine steps the tune word until the oscillator is centred.
// [RULE_08] The host changes the calibration control register only while held.
// [RULE_09] The complete flag reads 1 after calibration, or when calibration was skipped.
// [RULE_10] The run bit, reset 1, runs converter calibration when high and holds it when low.
// [RULE_11] Clearing the run bit also resets the digital and serial link clock dividers.
// [RULE_12] The host clears the run bit before changing marked settings, then sets it again.
// [RULE_13] The host sets the run bit before enabling the serial link.
// [RULE_14] The host disables the serial link before clearing the run bit.
// [RULE_15] The host writes zero to every reserved bit.
// [RULE_16] The complete flag is low while held with calibration enabled.
// [RULE_17] Engine writes to the tune word win over host writes during calibration.
module pvc_cal_control (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic osc_fast,
  output logic [7:0] reg_rdata,
  output logic [6:0] osc_tune,
  output logic pll_hold,
  output logic cal_run,
  output logic divider_reset,
  output logic osc_cal_complete
);
  // ===========================================================
  // Register file
  logic [6:0] tune;
  logic hold;
  logic [2:0] settle_sel;
  logic cal_enable;
  logic run;
  logic [6:0] next_tune;
  logic next_hold;
  logic [2:0] next_settle_sel;
  logic next_cal_enable;
  logic next_run;
  logic [7:0] next_rdata;

  // ===========================================================
  // Tune engine
  pvc_pkg::pvc_state_t state;
  pvc_pkg::pvc_state_t next_state;
  logic [6:0] step;
  logic [6:0] next_step;
  logic complete;
  logic next_complete;
  logic engine_wr;
  logic [6:0] engine_tune;
  logic timer_load;
  logic settle_done;
  logic hold_now;
  logic enable_now;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  pvc_settle_timer u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(timer_load),
    .settle_code(settle_sel),
    .expired(settle_done)
  );

  // Binary search: each step keeps or clears the trial bit, then tries the next bit down.
  always_comb begin
    next_state = state;
    next_step = step;
    next_complete = complete;
    engine_wr = 1'b0;
    engine_tune = tune;
    timer_load = 1'b0;
    // Look through a write in this cycle, so the flag never lags the registers by a cycle.
    hold_now = hold;
    enable_now = cal_enable;
    if (reg_wr && hit(reg_addr, `PVC_ADDR_HOLD)) begin
      hold_now = reg_wdata[0];
    end
    if (reg_wr && hit(reg_addr, `PVC_ADDR_CTRL)) begin
      enable_now = reg_wdata[0];
    end
    unique case (state)
      pvc_pkg::PVC_IDLE: begin
        if (hold) begin
          next_complete = !enable_now; // RULE_16
        end else if (cal_enable) begin
          next_state = pvc_pkg::PVC_STEP; // RULE_06
          next_step = `PVC_TUNE_MID;
          next_complete = 1'b0;
          // The search needs every bit below the trial bit at zero, whatever the host left.
          engine_wr = 1'b1;
          engine_tune = 7'h00; // RULE_07
        end else begin
          next_state = pvc_pkg::PVC_DONE;
          next_complete = 1'b1; // RULE_09
        end
      end
      pvc_pkg::PVC_STEP: begin
        engine_wr = 1'b1;
        engine_tune = tune | step; // RULE_07
        timer_load = 1'b1;
        next_state = pvc_pkg::PVC_SETTLE;
      end
      pvc_pkg::PVC_SETTLE: begin
        if (settle_done) begin
          engine_wr = 1'b1;
          // A fast oscillator means the trial bit overshoots, so drop it.
          engine_tune = osc_fast ? (tune & ~step) : tune; // RULE_07
          next_step = step >> 1;
          if (step == 7'h01) begin
            next_state = pvc_pkg::PVC_DONE;
            next_complete = 1'b1; // RULE_09
          end else begin
            next_state = pvc_pkg::PVC_STEP;
          end
        end
      end
      pvc_pkg::PVC_DONE: begin
        if (hold) begin
          next_state = pvc_pkg::PVC_IDLE;
          next_complete = !enable_now; // RULE_16
        end
      end
    endcase
    // Hold also aborts a search in progress, so the next release starts from the top.
    if (hold) begin
      next_state = pvc_pkg::PVC_IDLE;
      next_complete = !enable_now; // RULE_16
      engine_wr = 1'b0;
      timer_load = 1'b0;
    end
    if (hold_now && enable_now) begin
      next_complete = 1'b0; // RULE_16
    end
  end

  always_comb begin
    next_tune = tune;
    next_hold = hold;
    next_settle_sel = settle_sel;
    next_cal_enable = cal_enable;
    next_run = run;
    if (reg_wr) begin
      if (hit(reg_addr, `PVC_ADDR_TUNE)) begin
        next_tune = reg_wdata[`PVC_TUNE_MSB:0]; // RULE_01
      end
      if (hit(reg_addr, `PVC_ADDR_HOLD)) begin
        next_hold = reg_wdata[0];
      end
      if (hit(reg_addr, `PVC_ADDR_CTRL)) begin
        next_settle_sel = reg_wdata[`PVC_SETTLE_MSB:`PVC_SETTLE_LSB]; // RULE_05
        next_cal_enable = reg_wdata[0];
      end
      if (hit(reg_addr, `PVC_ADDR_RUN)) begin
        next_run = reg_wdata[0]; // RULE_10
      end
    end
    if (engine_wr) begin
      next_tune = engine_tune; // RULE_17
    end
  end

  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      next_rdata = 8'h00;
      if (hit(reg_addr, `PVC_ADDR_TUNE)) next_rdata = {1'b0, tune};
      if (hit(reg_addr, `PVC_ADDR_HOLD)) next_rdata = {7'h00, hold};
      if (hit(reg_addr, `PVC_ADDR_CTRL)) next_rdata = {1'b0, settle_sel, 3'h0, cal_enable};
      if (hit(reg_addr, `PVC_ADDR_STAT)) next_rdata = {7'h00, complete}; // RULE_09
      if (hit(reg_addr, `PVC_ADDR_RUN)) next_rdata = {7'h00, run};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tune <= `PVC_RST_TUNE;
      hold <= `PVC_RST_HOLD;
      settle_sel <= `PVC_RST_SETTLE;
      cal_enable <= `PVC_RST_CALEN;
      run <= `PVC_RST_RUN;
      reg_rdata <= 8'h00;
      state <= pvc_pkg::PVC_IDLE;
      step <= 7'h00;
      complete <= 1'b0;
      osc_tune <= `PVC_RST_TUNE;
      pll_hold <= `PVC_RST_HOLD;
      cal_run <= `PVC_RST_RUN;
      divider_reset <= 1'b0;
      osc_cal_complete <= 1'b0;
    end else begin
      tune <= next_tune;
      hold <= next_hold;
      settle_sel <= next_settle_sel;
      cal_enable <= next_cal_enable;
      run <= next_run;
      reg_rdata <= next_rdata;
      state <= next_state;
      step <= next_step;
      complete <= next_complete;
      osc_tune <= next_tune;
      pll_hold <= next_hold;
      cal_run <= next_run; // RULE_10
      divider_reset <= !next_run; // RULE_11
      osc_cal_complete <= next_complete;
    end
  end

  // ===========================================================
  // Checks
  sequence s_release;
    $fell(hold) && cal_enable;
  endsequence

  a_run_divider: assert property (@(posedge ref_clk) disable iff (!rst_n)
    divider_reset == !cal_run) else $error("divider reset not tied to run"); // RULE_11
  a_run_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && hit(reg_addr, `PVC_ADDR_RUN) |=> cal_run == $past(reg_wdata[0]))
    else $error("run bit not written"); // RULE_10
  a_cal_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_release |=> !complete && state == pvc_pkg::PVC_STEP)
    else $error("calibration did not start"); // RULE_06
  a_skip_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == pvc_pkg::PVC_IDLE && !hold && !cal_enable |=> complete)
    else $error("skip did not complete"); // RULE_09
  a_held_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hold && cal_enable && !reg_wr |=> !complete) else $error("complete high while held"); // RULE_16
  a_engine_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    engine_wr |=> tune == $past(engine_tune)) else $error("host overrode engine"); // RULE_17
  a_settle_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == pvc_pkg::PVC_STEP |=> state == pvc_pkg::PVC_SETTLE [*7])
    else $error("settle too short"); // RULE_05
  a_tune_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && hit(reg_addr, `PVC_ADDR_TUNE) && !engine_wr |=> osc_tune == $past(reg_wdata[6:0]))
    else $error("tune write lost"); // RULE_01
  a_cal_ends: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_release ##1 !hold [*8] |-> ##[1:480] complete || hold)
    else $error("calibration did not end"); // RULE_07
endmodule
`default_nettype wire

// *** verif/pvc_cal_control_tb.sv ***
// Self-checking testbench for the PLL oscillator and converter calibration control.
`timescale 1ns/1ps
`default_nettype none
`include "pvc_params.svh"
module pvc_cal_control_tb;
  logic ref_clk, rst_n, reg_wr, reg_rd, osc_fast;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [6:0] osc_tune, target;
  logic pll_hold, cal_run, divider_reset, osc_cal_complete;
  int failures, total_checks, cycles, span0, span1;

  pvc_cal_control dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .osc_fast(osc_fast), .reg_rdata(reg_rdata),
    .osc_tune(osc_tune), .pll_hold(pll_hold), .cal_run(cal_run),
    .divider_reset(divider_reset), .osc_cal_complete(osc_cal_complete));

  // ==========================================================================
  // Clock, comparator stand-in and run limit
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // The comparator is registered, so the engine sees the verdict a cycle after each step.
  always @(posedge ref_clk) osc_fast <= (osc_tune > target);

  // The whole sequence needs well under a thousand cycles; a hang ends at this ceiling.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      results();
    end
  end

  // ==========================================================================
  // Bus cycles and comparisons
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    chk8(rd_val, exp);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic reset_values;
    rdchk(`PVC_ADDR_TUNE, 8'h00);
    rdchk(`PVC_ADDR_HOLD, 8'h00);
    rdchk(`PVC_ADDR_CTRL, 8'h40);
    rdchk(`PVC_ADDR_STAT, 8'h01);
    rdchk(`PVC_ADDR_RUN, 8'h01);
    rdchk(8'h5A, 8'h00);
    chk1(divider_reset, 1'b0);
  endtask

  task automatic tune_host;
    wr(`PVC_ADDR_TUNE, 8'h7F);
    chk8({1'b0, osc_tune}, 8'h7F);
    rdchk(`PVC_ADDR_TUNE, 8'h7F);
    wr(`PVC_ADDR_STAT, 8'h00);
    rdchk(`PVC_ADDR_STAT, 8'h01);
  endtask

  task automatic calibrate(input logic [2:0] code, input logic [6:0] tgt, output int span);
    target = tgt;
    wr(`PVC_ADDR_HOLD, 8'h01);
    wr(`PVC_ADDR_CTRL, {1'b0, code, 4'h1});
    chk1(osc_cal_complete, 1'b0);
    repeat (20) @(posedge ref_clk);
    #1;
    chk1(osc_cal_complete, 1'b0);
    wr(`PVC_ADDR_HOLD, 8'h00);
    span = 0;
    while (osc_cal_complete !== 1'b1 && span < 600) begin
      @(posedge ref_clk);
      #1;
      span++;
    end
    chk1(osc_cal_complete, 1'b1);
    chk8({1'b0, osc_tune}, {1'b0, tgt});
    rdchk(`PVC_ADDR_TUNE, {1'b0, tgt});
  endtask

  task automatic skip_cal;
    wr(`PVC_ADDR_HOLD, 8'h01);
    wr(`PVC_ADDR_CTRL, 8'h40);
    wr(`PVC_ADDR_HOLD, 8'h00);
    repeat (3) @(posedge ref_clk);
    #1;
    chk1(osc_cal_complete, 1'b1);
    chk8({1'b0, osc_tune}, 8'h55);
  endtask

  task automatic run_bit;
    wr(`PVC_ADDR_RUN, 8'h00);
    rdchk(`PVC_ADDR_RUN, 8'h00);
    chk1(cal_run, 1'b0);
    chk1(divider_reset, 1'b1);
    wr(`PVC_ADDR_RUN, 8'h01);
    rdchk(`PVC_ADDR_RUN, 8'h01);
    chk1(cal_run, 1'b1);
    chk1(divider_reset, 1'b0);
  endtask

  task automatic results;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    target = 7'h00;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    reset_values();
    tune_host();
    calibrate(3'h0, 7'h2A, span0);
    calibrate(3'h1, 7'h55, span1);
    // Each of the seven steps waits eight cycles longer with the next settle code.
    chk8(8'(span1 - span0), 8'h38);
    skip_cal();
    run_bit();
    results();
  end
endmodule
`default_nettype wire
